// *** eeprom_page_host.sv ***
// Contract
// - next byte load starts inside load window
// - page address constant for whole page
// - low fifteen address bits carry command codes
// - three writes enable protection or unlock
// - six writes disable protection
// - protected block needs unlock before writes
// - page load limited to page size
`timescale 1ns/1ps
module eeprom_page_host
    import eeprom_host_pkg::*;
#(
    parameter int BLOCK_LSB = 17,
    parameter int BLOCK_W = 2,
    parameter int OFFS_W = 7,
    parameter int TWC_CYCLES = TWC_CYC,
    parameter int PWRUP_CYCLES = PWRUP_CYC,
    parameter int BLW_CYCLES = BLW_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic loadValid,
    output logic loadReady,
    input wire logic [OFFS_W-1:0] loadIdx,
    input wire logic [7:0] loadData,
    input wire logic reqValid,
    output logic reqReady,
    input wire eeprom_host_pkg::request_t req,
    output logic busy,
    output logic done,
    output eeprom_host_pkg::pins_t pins,
    input wire logic [7:0] dataIn
);
    import eeprom_host_pkg::*;

    localparam int PAGE_BYTES = 1 << OFFS_W;
    localparam logic [7:0] PAGE_MAX = 8'(PAGE_BYTES);
    localparam logic [ADDR_W-1:0] BLOCK_MASK =
        ADDR_W'((1 << (BLOCK_LSB + BLOCK_W)) - (1 << BLOCK_LSB));
    localparam logic [ADDR_W-1:0] PAGE_MASK =
        ADDR_W'((1 << BLOCK_LSB) - (1 << OFFS_W));
    localparam logic [ADDR_W-1:0] OFFS_MASK =
        ADDR_W'((1 << OFFS_W) - 1);

    typedef enum logic [2:0]
    {
        ST_POWERUP, ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_PROGRAM
    } state_t;

    state_t state, next_state;
    logic [31:0] cnt, next_cnt;
    logic [7:0] seqIdx, next_seqIdx;
    logic [7:0] total, next_total;
    request_t cur, next_cur;
    pins_t next_pins;
    logic next_done;

    // number of command writes in front of the page bytes
    function automatic logic [2:0] cmdLen(op_t op);
        logic [2:0] n;
        n = LEN_PLAIN;
        unique case (op)
            OP_PLAIN: n = LEN_PLAIN;
            OP_PROTECT: n = LEN_PROTECT;
            OP_UNPROTECT: n = LEN_UNPROTECT;
            default: n = LEN_PLAIN;
        endcase
        return n;
    endfunction

    // command code for one step: {address, data}
    function automatic logic [22:0] cmdWord(op_t op, logic [7:0] idx);
        logic [22:0] w;
        w = {ADR_5555, DAT_AA};
        if (op == OP_UNPROTECT)
        begin
            unique case (idx)
                8'h00: w = {ADR_5555, DAT_AA};
                8'h01: w = {ADR_2AAA, DAT_55};
                8'h02: w = {ADR_5555, DAT_80};
                8'h03: w = {ADR_5555, DAT_AA};
                8'h04: w = {ADR_2AAA, DAT_55};
                default: w = {ADR_5555, DAT_20};
            endcase
        end
        else
        begin
            unique case (idx)
                8'h00: w = {ADR_5555, DAT_AA};
                8'h01: w = {ADR_2AAA, DAT_55};
                default: w = {ADR_5555, DAT_A0};
            endcase
        end
        return w;
    endfunction

    // block lines sit above the page and offset fields
    function automatic logic [ADDR_W-1:0] blockBits(logic [2:0] blk);
        // width and position set per variant
        return (ADDR_W'(blk) << BLOCK_LSB) & BLOCK_MASK;
    endfunction

    // page bytes reuse the request's block and page
    wire logic [2:0] curLen = cmdLen(cur.op);
    wire logic isCmd = seqIdx < {5'h00, curLen};
    wire logic [7:0] offset = seqIdx - {5'h00, curLen};
    wire logic [22:0] cmdNow = cmdWord(cur.op, seqIdx);
    wire logic [7:0] memData;
    wire logic [7:0] clampCount =
        (req.count > PAGE_MAX) ? PAGE_MAX : req.count;
    wire logic [7:0] reqTotal = clampCount + {5'h00, cmdLen(req.op)};
    // only the low fifteen bits carry the code
    wire logic [ADDR_W-1:0] cmdAddr =
        blockBits(cur.block) | ADDR_W'(cmdNow[22:8]);
    // page field held from the request all page long
    wire logic [ADDR_W-1:0] pageAddr = blockBits(cur.block) |
        ((ADDR_W'(cur.page) << OFFS_W) & PAGE_MASK) |
        (ADDR_W'(offset) & OFFS_MASK);
    wire logic [ADDR_W-1:0] byteAddr = isCmd ? cmdAddr : pageAddr;
    wire logic [7:0] byteData = isCmd ? cmdNow[7:0] : memData;

    // buffer is only loaded while no transfer reads it
    assign loadReady = (state == ST_IDLE);
    assign reqReady = (state == ST_IDLE);
    assign busy = (state != ST_IDLE);

    page_buffer #(
        .WIDTH(8),
        .DEPTH(PAGE_BYTES),
        .AW(OFFS_W)
    ) buffer (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(loadValid && loadReady),
        .wrAddr(loadIdx),
        .wrData(loadData),
        .rdAddr(offset[OFFS_W-1:0]),
        .rdData(memData)
    );

    // sequencer: each byte is setup, strobe low, then hold
    always_comb
    begin
        next_state = state;
        next_cnt = cnt + 32'h0000_0001;
        next_seqIdx = seqIdx;
        next_total = total;
        next_cur = cur;
        next_pins = pins;
        next_done = 1'b0;
        unique case (state)
            ST_POWERUP:
            begin
                // stay off the bus until device accepts writes
                if (cnt >= 32'(PWRUP_CYCLES - 1))
                begin
                    next_state = ST_IDLE;
                    next_cnt = '0;
                end
            end
            ST_IDLE:
            begin
                next_cnt = '0;
                if (reqValid)
                begin
                    next_cur = req;
                    next_total = reqTotal;
                    next_seqIdx = '0;
                    if (reqTotal == 8'h00)
                        next_done = 1'b1;
                    else
                        next_state = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // output enable stays high for writes
                next_pins.oeN = 1'b1;
                next_pins.csN = 1'b0;
                if (cnt == 32'h0000_0001)
                begin
                    next_pins.addr = byteAddr;
                    next_pins.data = byteData;
                    next_pins.dataDriveN = 1'b0;
                end
                if (cnt == 32'(AS_CYC + 1))
                begin
                    next_pins.weN = 1'b0;
                    next_state = ST_PULSE;
                    next_cnt = '0;
                end
            end
            ST_PULSE:
            begin
                // strobe far wider than any glitch
                if (cnt == 32'(WP_CYC - 1))
                begin
                    next_pins.weN = 1'b1;
                    next_state = ST_HOLD;
                    next_cnt = '0;
                end
            end
            ST_HOLD:
            begin
                if (cnt == 32'(HOLD_CYC - 1))
                begin
                    next_cnt = '0;
                    if (seqIdx == total - 8'h01)
                    begin
                        next_pins.dataDriveN = 1'b1;
                        next_pins.csN = 1'b1;
                        next_state = ST_PROGRAM;
                    end
                    else
                    begin
                        // next strobe well inside load window
                        next_seqIdx = seqIdx + 8'h01;
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_PROGRAM:
            begin
                // wait full cycle so protect state settles
                if (cnt == 32'(TWC_CYCLES - 1))
                begin
                    next_state = ST_IDLE;
                    next_cnt = '0;
                    next_done = 1'b1;
                end
            end
        endcase
    end

    // pins idle: deselected, strobes high, bus released
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= ST_POWERUP;
            cnt <= '0;
            seqIdx <= '0;
            total <= '0;
            cur <= '0;
            pins <= {ADDR_RST, DATA_RST, 1'b1, 1'b1, 1'b1, 1'b1};
            done <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            seqIdx <= next_seqIdx;
            total <= next_total;
            cur <= next_cur;
            pins <= next_pins;
            done <= next_done;
        end
    end
endmodule

// *** eeprom_host_pkg.sv ***
package eeprom_host_pkg;

    // clock and timing, each figure in its own unit
    localparam int CLK_NS = 5;
    localparam int WP_NS = 150;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int AS_NS = 30;
    localparam int AS_CYC = (AS_NS + CLK_NS - 1) / CLK_NS;
    localparam int AH_NS = 125;
    localparam int AH_CYC = (AH_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_NS = 50;
    localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (AH_CYC > WPH_CYC) ? AH_CYC : WPH_CYC;
    localparam int BLW_US = 150;
    localparam int BLW_CYC = BLW_US * 1000 / CLK_NS;
    localparam int TWC_MS = 10;
    localparam int TWC_CYC = TWC_MS * 1000000 / CLK_NS;
    localparam int PWRUP_MS = 5;
    localparam int PWRUP_CYC = PWRUP_MS * 1000000 / CLK_NS;

    // pin widths
    localparam int ADDR_W = 19;
    localparam int CODE_W = 15;

    // command sequence codes
    localparam logic [7:0] DAT_AA = 8'hAA;
    localparam logic [7:0] DAT_55 = 8'h55;
    localparam logic [7:0] DAT_A0 = 8'hA0;
    localparam logic [7:0] DAT_80 = 8'h80;
    localparam logic [7:0] DAT_20 = 8'h20;
    localparam logic [14:0] ADR_5555 = 15'h5555;
    localparam logic [14:0] ADR_2AAA = 15'h2AAA;
    localparam logic [2:0] LEN_PLAIN = 3'h0;
    localparam logic [2:0] LEN_PROTECT = 3'h3;
    localparam logic [2:0] LEN_UNPROTECT = 3'h6;

    // reset values of the pins
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h0_0000;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic [1:0] {OP_PLAIN, OP_PROTECT, OP_UNPROTECT} op_t;

    typedef struct packed {
        op_t op;
        logic [2:0] block;
        logic [9:0] page;
        logic [7:0] count;
    } request_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic dataDriveN;
        logic csN;
        logic weN;
        logic oeN;
    } pins_t;

endpackage

// *** page_buffer.sv ***
`timescale 1ns/1ps
module page_buffer
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW = 7
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    // storage has no reset, only the read register does
    always_ff @(posedge clk)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
    end

    // read data always comes out of a register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdData <= '0;
        else
            rdData <= mem[rdAddr];
    end
endmodule

// *** eeprom_host_monitor.sv ***
`timescale 1ns/1ps
module eeprom_host_monitor
    import eeprom_host_pkg::*;
#(
    parameter int BLOCK_LSB = 17,
    parameter int BLOCK_W = 2
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire eeprom_host_pkg::request_t req,
    input wire logic done,
    input wire eeprom_host_pkg::pins_t pins
);
    logic [2:0] curBlock;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // block of the transfer in flight
    always_ff @(posedge clk)
        if (reqValid && reqReady)
            curBlock <= req.block;
    sequence s_take(op_t o);
        reqValid && reqReady && req.op == o;
    endsequence
    sequence s_fall(logic [7:0] d, logic [14:0] a);
        $fell(pins.weN) && pins.data == d && pins.addr[14:0] == a;
    endsequence
    a_output_off: assert property (pins.oeN)
        else $error("output enable low");
    a_strobe_width: assert property ($fell(pins.weN) |->
        ##29 !pins.weN ##1 pins.weN) else $error("strobe width");
    a_select_spans: assert property (!pins.weN |->
        !pins.csN && !pins.dataDriveN) else $error("select lost");
    a_addr_steady: assert property (!pins.weN && !$past(pins.weN)
        |-> $stable(pins.addr) && $stable(pins.data))
        else $error("address moved");
    a_next_load: assert property ($rose(pins.weN) |->
        ##[1:40] (pins.csN || $fell(pins.weN))) else $error("slow load");
    a_first_code: assert property (s_take(OP_PROTECT) |->
        ##[1:20] s_fall(DAT_AA, ADR_5555)) else $error("first code");
    a_second_code: assert property (s_take(OP_UNPROTECT) |->
        ##[50:90] s_fall(DAT_55, ADR_2AAA)) else $error("second code");
    a_lock_code: assert property (s_take(OP_PROTECT) |->
        ##[120:150] s_fall(DAT_A0, ADR_5555)) else $error("lock code");
    a_free_code: assert property (s_take(OP_UNPROTECT) |->
        ##[120:150] s_fall(DAT_80, ADR_5555)) else $error("free code");
    a_block_bits: assert property (!pins.weN |->
        pins.addr[BLOCK_LSB +: BLOCK_W] == curBlock[BLOCK_W-1:0])
        else $error("block bits");
    a_done_pulse: assert property (done |=> !done)
        else $error("done too long");
endmodule

bind eeprom_page_host eeprom_host_monitor #(.BLOCK_LSB(BLOCK_LSB),
    .BLOCK_W(BLOCK_W)) mon (.clk(clk), .rst_n(rst_n),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .done(done),
    .pins(pins));

// *** eeprom_dev_model.sv ***
`timescale 1ns/1ps
module eeprom_dev_model
    import eeprom_host_pkg::*;
#(
    parameter int BLOCK_LSB = 17,
    parameter int BLOCK_W = 2,
    parameter realtime WIN_NS = 400.0,
    parameter realtime PROG_NS = 500.0,
    parameter realtime PWR_NS = 50.0
)
(
    input wire eeprom_host_pkg::pins_t pins,
    output logic [7:0] dataOut
);
    localparam logic [22:0] CODES [6] = '{{DAT_AA, ADR_5555},
        {DAT_55, ADR_2AAA}, {DAT_80, ADR_5555}, {DAT_AA, ADR_5555},
        {DAT_55, ADR_2AAA}, {DAT_20, ADR_5555}};
    // one flag per block, never reset
    logic [7:0] prot = 8'h00;
    logic [7:0] mem [int];
    logic [18:0] adr;
    logic [18:0] wa [$];
    logic [7:0] wd [$];
    realtime tFall = -1.0;
    realtime tLast;
    bit ok;
    bit prog;
    event kick;
    // released bus shows the inverse of the last byte
    assign dataOut = pins.dataDriveN ? ~pins.data : pins.data;
    // no write at power-up or with output on
    always @(negedge pins.weN)
    begin
        adr = pins.addr;
        ok = !pins.csN && pins.oeN && $realtime > PWR_NS;
        tFall = ok ? $realtime : -1.0;
    end
    // glitches and busy device take nothing
    always @(posedge pins.weN)
        if (tFall >= 0 && $realtime - tFall >= 8.0 && !prog)
        begin
            wa.push_back(adr);
            wd.push_back(pins.data);
            tLast = $realtime;
            -> kick;
        end
    function automatic bit hit(int i, logic [22:0] c);
        return wa.size() > i && {wd[i], wa[i][14:0]} == c;
    endfunction
    always
    begin
        @(kick);
        while ($realtime < tLast + WIN_NS)
            #(tLast + WIN_NS - $realtime);
        prog = 1;
        #(PROG_NS);
        commit();
        prog = 0;
    end
    // block field per variant
    // decided at page close, so a bad code leaves an ordinary write
    task automatic commit();
        bit unp;
        bit pro;
        int n;
        logic [BLOCK_W-1:0] b;
        b = wa[0][BLOCK_LSB +: BLOCK_W];
        pro = hit(0, CODES[0]) && hit(1, CODES[1]);
        unp = pro;
        for (int i = 2; i < 6; i++)
            unp = unp && hit(i, CODES[i]);
        pro = pro && hit(2, {DAT_A0, ADR_5555});
        n = unp ? 6 : (pro ? 3 : 0);
        if (n > 0)
            prot[b] = pro;
        for (int i = n; i < wa.size(); i++)
            if (n > 0 || !prot[wa[i][BLOCK_LSB +: BLOCK_W]])
                mem[wa[i]] = wd[i];
        wa.delete();
        wd.delete();
    endtask
endmodule

// *** tb_eeprom_page_host.sv ***
`timescale 1ns/1ps
module tb_eeprom_page_host;
    import eeprom_host_pkg::*;
    logic clk, rst_n, loadValid, reqValid, loadReady, reqReady, busy, done;
    logic [6:0] loadIdx;
    logic [7:0] loadData, dataIn;
    request_t req;
    pins_t pins;
    int err_count, compares;
    int cyc = 0;
    // short programming time keeps the run small
    eeprom_page_host #(.TWC_CYCLES(200), .PWRUP_CYCLES(4)) uut (
        .clk(clk), .rst_n(rst_n), .loadValid(loadValid),
        .loadReady(loadReady), .loadIdx(loadIdx), .loadData(loadData),
        .reqValid(reqValid), .reqReady(reqReady), .req(req), .busy(busy),
        .done(done), .pins(pins), .dataIn(dataIn));
    eeprom_dev_model dev (.pins(pins), .dataOut(dataIn));
    initial
    begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task automatic stop_test();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] rd(int b, int p, int o);
        int a;
        a = b << 17 | p << 7 | o;
        return dev.mem.exists(a) ? dev.mem[a] : 8'hFF;
    endfunction
    task automatic load(int i, logic [7:0] d);
        @(negedge clk);
        // buffer refuses bytes during the power-up wait
        while (loadReady !== 1'b1)
            @(negedge clk);
        loadValid = 1;
        loadIdx = i[6:0];
        loadData = d;
        @(negedge clk);
        loadValid = 0;
    endtask
    // one transfer, waits for done under a bound
    task automatic run(op_t op, int blk, int pg, int n);
        int t;
        t = 0;
        @(negedge clk);
        while (reqReady !== 1'b1 && t < 100)
        begin
            @(negedge clk);
            t++;
        end
        reqValid = 1;
        req = '{op, blk[2:0], pg[9:0], n[7:0]};
        @(negedge clk);
        reqValid = 0;
        while (done !== 1'b1 && t < 20000)
        begin
            @(negedge clk);
            t++;
        end
        // a lost done counts against the run
        if (done !== 1'b1)
        begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, done, 1'b1);
        end
    endtask
    task automatic t_plain();
        load(0, 8'h11);
        load(1, 8'h22);
        run(OP_PLAIN, 1, 3, 2);
        chk({7'h00, busy}, 8'h00);
        chk(rd(1, 3, 0), 8'h11);
        chk(rd(1, 3, 1), 8'h22);
        chk(rd(1, 3, 2), 8'hFF);
    endtask
    task automatic t_lock();
        run(OP_PROTECT, 1, 0, 0);
        chk({7'h00, dev.prot[1]}, 8'h01);
        load(0, 8'h33);
        run(OP_PLAIN, 1, 3, 1);
        chk(rd(1, 3, 0), 8'h11);
        run(OP_PLAIN, 2, 3, 1);
        chk(rd(2, 3, 0), 8'h33);
    endtask
    task automatic t_unlock();
        for (int i = 0; i < 128; i++)
            load(i, i[7:0] ^ 8'h5A);
        run(OP_PROTECT, 1, 5, 255);
        for (int i = 0; i < 128; i++)
            chk(rd(1, 5, i), i[7:0] ^ 8'h5A);
        chk(rd(1, 6, 0), 8'hFF);
        chk({7'h00, dev.prot[1]}, 8'h01);
    endtask
    task automatic t_free();
        run(OP_UNPROTECT, 1, 0, 0);
        chk({7'h00, dev.prot[1]}, 8'h00);
        load(0, 8'h44);
        run(OP_PLAIN, 1, 3, 1);
        chk(rd(1, 3, 0), 8'h44);
    endtask
    initial
    begin
        rst_n = 0;
        loadValid = 0;
        reqValid = 0;
        loadIdx = 0;
        loadData = 0;
        req = '0;
        err_count = 0;
        compares = 0;
        repeat (12) @(negedge clk);
        rst_n = 1;
        t_plain();
        t_lock();
        t_unlock();
        t_free();
        stop_test();
    end
endmodule
